/* File: rtl/itsb_pkg.sv */
// Constants, types and the register map of the trajectory segment buffer.
// Assumes a 32-bit APB slave port with byte addresses in the low eight bits.
package itsb_pkg;
  // ==========================================================
  // Sizes
  localparam int ITSB_DEPTH = 32;
  localparam int ITSB_MIN_SEGS = 2;
  localparam int ITSB_ID_W = 7;
  localparam int ITSB_POS_W = 32;
  localparam int ITSB_TIME_W = 16;
  localparam int ITSB_CTRL_W = 16;
  localparam int ITSB_ADDR_W = 8;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] ITSB_CTRL_OFS = 8'h00;
  localparam logic [7:0] ITSB_CONFIG_OFS = 8'h04;
  localparam logic [7:0] ITSB_INTERVAL_OFS = 8'h08;
  localparam logic [7:0] ITSB_SEG_POS_OFS = 8'h0C;
  localparam logic [7:0] ITSB_SEG_VEL_OFS = 8'h10;
  localparam logic [7:0] ITSB_SEG_CMD_OFS = 8'h14;
  localparam logic [7:0] ITSB_STATUS_OFS = 8'h18;
  // ==========================================================
  // Field positions and reset values
  localparam int ITSB_CTRL_QSTOP = 2;
  localparam int ITSB_CTRL_ENABLE = 4;
  localparam int ITSB_CTRL_HALT = 8;
  localparam logic [15:0] ITSB_CTRL_RST = 16'h0000;
  localparam int ITSB_CFG_SYNC = 8;
  localparam int ITSB_HDR_CMD = 7;
  localparam int ITSB_TIME_LSB = 8;
  localparam logic [6:0] ITSB_CMD_CLEAR = 7'h00;
  localparam int ITSB_ST_UNDER = 0;
  localparam int ITSB_ST_OVER = 1;
  localparam int ITSB_ST_SEQ = 2;
  localparam int ITSB_ST_MOVING = 3;
  localparam int ITSB_ST_FINISH = 4;
  localparam int ITSB_ST_NEXTID = 8;
  localparam int ITSB_ST_COUNT = 16;
  localparam int ITSB_ST_FREE = 24;
  // ==========================================================
  // Interpolation submode codes
  localparam logic signed [7:0] ITSB_SUB_LIN_CONST = 8'sh00;
  localparam logic signed [7:0] ITSB_SUB_LIN_VAR = 8'shFF;
  localparam logic signed [7:0] ITSB_SUB_CUBIC = 8'shFE;
  // ==========================================================
  // Types
  typedef enum logic [1:0]
  {
    ITSB_IDLE = 2'b00,
    ITSB_RUN = 2'b01,
    ITSB_FINISH = 2'b11
  } itsb_state_t;
  typedef struct packed
  {
    logic [ITSB_POS_W-1:0] pos;
    logic [ITSB_POS_W-1:0] vel;
    logic [ITSB_TIME_W-1:0] segTime;
  } itsb_entry_t;
  localparam int ITSB_ENTRY_W = $bits(itsb_entry_t);
endpackage

/* File: rtl/itsb_seg_fifo.sv */
// Segment storage: flip-flop ring with head and head+1 read ports.
// Assumes the caller never pops more entries than are held.
`timescale 1ns/1ps
`default_nettype none
module itsb_seg_fifo #(
  parameter int W = 80,
  parameter int DEPTH = 32,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic push,
  input wire logic [W-1:0] pushData,
  input wire logic [1:0] pop,
  input wire logic flush,
  output logic [AW:0] count,
  output logic full,
  output logic [W-1:0] headData,
  output logic [W-1:0] nextData
);
  typedef struct packed
  {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] rdPtr;
    logic [AW-1:0] wrPtr;
    logic [AW:0] count;
  } itsb_fifo_t;
  itsb_fifo_t r;
  itsb_fifo_t next_r;
  logic doPush;

  // ==========================================================
  // Pointer and storage update; flush beats push and pop
  always_comb
  begin
    next_r = r;
    doPush = push && !full;
    if (flush)
    begin
      next_r.rdPtr = '0;
      next_r.wrPtr = '0;
      next_r.count = '0;
    end
    else
    begin
      if (doPush)
      begin
        next_r.mem[r.wrPtr] = pushData;
        next_r.wrPtr = r.wrPtr + AW'(1);
      end
      next_r.rdPtr = r.rdPtr + AW'(pop);
      next_r.count = r.count + (AW+1)'(doPush) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      r.mem <= '0;
      r.rdPtr <= '0;
      r.wrPtr <= '0;
      r.count <= '0;
    end
    else if (ce)
    begin
      r <= next_r;
    end
  end

  // Storage is cleared at reset too, so the span outputs never carry unknowns
  assign count = r.count;
  assign full = (r.count == (AW+1)'(DEPTH));
  assign headData = r.mem[r.rdPtr];
  assign nextData = r.mem[r.rdPtr + AW'(1)];
endmodule
`default_nettype wire

/* File: rtl/itsb_seq_check.sv */
// Segment identifier check with a latched sequencing error.
// Assumes one segment strobe per cycle at most.
`timescale 1ns/1ps
`default_nettype none
module itsb_seq_check
  import itsb_pkg::*;
#(
  parameter int ID_W = ITSB_ID_W
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic segStrobe,
  input wire logic [ID_W-1:0] segId,
  input wire logic room,
  input wire logic clearErr,
  output logic accept,
  output logic overflowHit,
  output logic seqErr,
  output logic [ID_W-1:0] nextId
);
  typedef struct packed
  {
    logic err;
    logic [ID_W-1:0] expected;
  } itsb_seq_t;
  itsb_seq_t r;
  itsb_seq_t next_r;
  logic inOrder;

  // ==========================================================
  // A latched error rejects everything until a buffer command
  always_comb
  begin
    next_r = r;
    inOrder = segStrobe && !r.err && (segId == r.expected);
    accept = inOrder && room;
    overflowHit = inOrder && !room;
    if (clearErr)
    begin
      next_r.err = 1'b0;
    end
    // Set after clear, so a mismatch in the clearing cycle survives
    if (segStrobe && !r.err && (segId != r.expected))
    begin
      next_r.err = 1'b1;
    end
    if (accept)
    begin
      next_r.expected = r.expected + ID_W'(1);
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      r <= '0;
    end
    else if (ce)
    begin
      r <= next_r;
    end
  end

  assign seqErr = r.err;
  assign nextId = r.expected;
endmodule
`default_nettype wire

/* File: rtl/itsb_top.sv */
// Interpolated-position trajectory segment buffer and move sequencer.
// Assumes an APB master on clk and an external interpolator that
// pulses spanDone when it reaches the end point of the current span.
//
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module itsb_top
  import itsb_pkg::*;
#(
  parameter int DEPTH = ITSB_DEPTH
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [itsb_pkg::ITSB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic spanDone,
  input wire logic syncTick,
  output logic moving,
  output logic signed [7:0] subMode,
  output logic [itsb_pkg::ITSB_POS_W-1:0] spanStartPos,
  output logic [itsb_pkg::ITSB_POS_W-1:0] spanEndPos,
  output logic [itsb_pkg::ITSB_POS_W-1:0] spanStartVel,
  output logic [itsb_pkg::ITSB_POS_W-1:0] spanEndVel,
  output logic [itsb_pkg::ITSB_TIME_W-1:0] spanTime
);
  import itsb_pkg::*;
  localparam int AW = $clog2(DEPTH);

  typedef struct packed
  {
    logic [ITSB_CTRL_W-1:0] ctrl;
    logic signed [7:0] subMode;
    logic syncEn;
    logic [ITSB_TIME_W-1:0] interval;
    logic [ITSB_POS_W-1:0] segPos;
    logic [ITSB_POS_W-1:0] segVel;
    itsb_state_t state;
    logic underflow;
    logic overflow;
    logic [31:0] rdata;
  } itsb_top_t;
  itsb_top_t r;
  itsb_top_t next_r;

  logic wrAcc;
  logic rdSetup;
  logic mapped;
  logic wrCmd;
  logic bufCmd;
  logic flushCmd;
  logic segStrobe;
  logic startReq;
  logic stopNow;
  logic advance;
  logic accept;
  logic overflowHit;
  logic seqErr;
  logic [ITSB_ID_W-1:0] nextId;
  logic [1:0] pop;
  logic flush;
  logic [AW:0] count;
  logic full;
  logic [AW:0] freeCount;
  itsb_entry_t pushEntry;
  itsb_entry_t headEntry;
  itsb_entry_t nextEntry;
  logic [ITSB_ENTRY_W-1:0] headBits;
  logic [ITSB_ENTRY_W-1:0] nextBits;

  // ==========================================================
  // APB decode: zero wait states, error on an unmapped address
  assign wrAcc = psel && penable && pwrite;
  assign rdSetup = psel && !penable && !pwrite;
  always_comb
  begin
    case (paddr)
      ITSB_CTRL_OFS, ITSB_CONFIG_OFS, ITSB_INTERVAL_OFS, ITSB_SEG_POS_OFS,
      ITSB_SEG_VEL_OFS, ITSB_SEG_CMD_OFS, ITSB_STATUS_OFS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // Segment command word: header byte, then the segment time
  assign wrCmd = wrAcc && (paddr == ITSB_SEG_CMD_OFS);
  assign bufCmd = wrCmd && pwdata[ITSB_HDR_CMD];
  assign flushCmd = bufCmd && (pwdata[ITSB_HDR_CMD-1:0] == ITSB_CMD_CLEAR);
  assign segStrobe = wrCmd && !pwdata[ITSB_HDR_CMD];

  // Constant-time linear mode takes its time from the interval setting
  always_comb
  begin
    pushEntry.pos = r.segPos;
    pushEntry.vel = r.segVel;
    if (r.subMode == ITSB_SUB_LIN_CONST)
    begin
      pushEntry.segTime = r.interval;
    end
    else
    begin
      pushEntry.segTime = pwdata[ITSB_TIME_LSB +: ITSB_TIME_W];
    end
  end

  // ==========================================================
  // Sequence checking and storage
  itsb_seq_check #(
    .ID_W(ITSB_ID_W)
  ) u_seq (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .segStrobe(segStrobe),
    .segId(pwdata[ITSB_ID_W-1:0]),
    .room(!full),
    .clearErr(bufCmd),
    .accept(accept),
    .overflowHit(overflowHit),
    .seqErr(seqErr),
    .nextId(nextId)
  );

  itsb_seg_fifo #(
    .W(ITSB_ENTRY_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .push(accept),
    .pushData(pushEntry),
    .pop(pop),
    .flush(flush),
    .count(count),
    .full(full),
    .headData(headBits),
    .nextData(nextBits)
  );
  assign headEntry = headBits;
  assign nextEntry = nextBits;
  assign freeCount = (AW+1)'(DEPTH) - count;

  // ==========================================================
  // Motion control terms
  // Start needs a write that takes bit 4 from 0 to 1
  assign startReq = wrAcc && (paddr == ITSB_CTRL_OFS) && pwdata[ITSB_CTRL_ENABLE]
    && !r.ctrl[ITSB_CTRL_ENABLE];
  assign stopNow = !r.ctrl[ITSB_CTRL_ENABLE]
    || !r.ctrl[ITSB_CTRL_QSTOP]
    || r.ctrl[ITSB_CTRL_HALT];
  // In synchronized operation a span ends only on a sync tick
  assign advance = spanDone && (!r.syncEn || syncTick);

  // ==========================================================
  // Register writes, read capture and the move sequencer
  always_comb
  begin
    next_r = r;
    pop = 2'd0;
    flush = flushCmd;
    if (wrAcc)
    begin
      case (paddr)
        ITSB_CTRL_OFS: next_r.ctrl = pwdata[ITSB_CTRL_W-1:0];
        ITSB_CONFIG_OFS:
        begin
          next_r.subMode = pwdata[7:0];
          next_r.syncEn = pwdata[ITSB_CFG_SYNC];
        end
        ITSB_INTERVAL_OFS: next_r.interval = pwdata[ITSB_TIME_W-1:0];
        ITSB_SEG_POS_OFS: next_r.segPos = pwdata;
        ITSB_SEG_VEL_OFS: next_r.segVel = pwdata;
        default: next_r.rdata = r.rdata;
      endcase
    end
    // Any buffer command clears the latched flags
    if (bufCmd)
    begin
      next_r.underflow = 1'b0;
      next_r.overflow = 1'b0;
    end
    if (overflowHit)
    begin
      next_r.overflow = 1'b1;
    end
    case (r.state)
      ITSB_IDLE:
      begin
        if (startReq && !flushCmd)
        begin
          if (count >= (AW+1)'(ITSB_MIN_SEGS))
          begin
            next_r.state = ITSB_RUN;
          end
          else
          begin
            next_r.underflow = 1'b1;
          end
        end
      end
      ITSB_RUN:
      begin
        if (stopNow || flushCmd)
        begin
          next_r.state = ITSB_IDLE;
        end
        else if (count < (AW+1)'(ITSB_MIN_SEGS))
        begin
          next_r.state = ITSB_IDLE;
          next_r.underflow = 1'b1;
        end
        else if (nextEntry.segTime == '0)
        begin
          next_r.state = ITSB_FINISH;
        end
        else if (advance)
        begin
          pop = 2'd1;
        end
      end
      ITSB_FINISH:
      begin
        // Reach the end point, then drop both the span and the end marker
        if (stopNow || flushCmd)
        begin
          next_r.state = ITSB_IDLE;
        end
        else if (advance)
        begin
          pop = 2'd2;
          next_r.state = ITSB_IDLE;
        end
      end
      default: next_r.state = ITSB_IDLE;
    endcase
    // Read data is captured in the setup cycle, ready in the access cycle
    if (rdSetup)
    begin
      case (paddr)
        ITSB_CTRL_OFS: next_r.rdata = 32'(r.ctrl);
        ITSB_CONFIG_OFS: next_r.rdata = {23'h000000, r.syncEn, r.subMode};
        ITSB_INTERVAL_OFS: next_r.rdata = 32'(r.interval);
        ITSB_SEG_POS_OFS: next_r.rdata = r.segPos;
        ITSB_SEG_VEL_OFS: next_r.rdata = r.segVel;
        ITSB_STATUS_OFS:
        begin
          next_r.rdata = '0;
          next_r.rdata[ITSB_ST_UNDER] = r.underflow;
          next_r.rdata[ITSB_ST_OVER] = r.overflow;
          next_r.rdata[ITSB_ST_SEQ] = seqErr;
          next_r.rdata[ITSB_ST_MOVING] = (r.state != ITSB_IDLE);
          next_r.rdata[ITSB_ST_FINISH] = (r.state == ITSB_FINISH);
          next_r.rdata[ITSB_ST_NEXTID +: ITSB_ID_W] = nextId;
          next_r.rdata[ITSB_ST_COUNT +: AW+1] = count;
          next_r.rdata[ITSB_ST_FREE +: AW+1] = freeCount;
        end
        default: next_r.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      r <= '0;
      r.ctrl <= ITSB_CTRL_RST;
      r.subMode <= ITSB_SUB_CUBIC;
      r.state <= ITSB_IDLE;
    end
    else if (ce)
    begin
      r <= next_r;
    end
  end

  // ==========================================================
  // Outputs to the interpolator; the span is head to head+1
  assign prdata = r.rdata;
  assign moving = (r.state != ITSB_IDLE);
  assign subMode = r.subMode;
  assign spanStartPos = headEntry.pos;
  assign spanStartVel = headEntry.vel;
  assign spanTime = headEntry.segTime;
  assign spanEndPos = nextEntry.pos;
  assign spanEndVel = nextEntry.vel;
endmodule
`default_nettype wire

/* File: tb/itsb_top_properties.sv */
// Port-level assertions for the trajectory segment buffer.
// Assumes ce stays high while a move is being observed.
`timescale 1ns/1ps
`default_nettype none
module itsb_checker
  import itsb_pkg::*;
#(
  parameter int DEPTH = ITSB_DEPTH
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [itsb_pkg::ITSB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic spanDone,
  input wire logic syncTick,
  input wire logic moving,
  input wire logic signed [7:0] subMode,
  input wire logic [itsb_pkg::ITSB_POS_W-1:0] spanStartPos,
  input wire logic [itsb_pkg::ITSB_POS_W-1:0] spanEndPos,
  input wire logic [itsb_pkg::ITSB_POS_W-1:0] spanStartVel,
  input wire logic [itsb_pkg::ITSB_POS_W-1:0] spanEndVel,
  input wire logic [itsb_pkg::ITSB_TIME_W-1:0] spanTime
);
  import itsb_pkg::*;
  // ==========================================================
  // Decoded write strobes
  logic anyWr;
  logic ctlWr;
  logic cmdWr;
  assign anyWr = psel && penable && pwrite && ce;
  assign ctlWr = anyWr && paddr == ITSB_CTRL_OFS;
  assign cmdWr = anyWr && paddr == ITSB_SEG_CMD_OFS;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ==========================================================
  // Move start and stop
  start_edge_a: assert property
    ($rose(moving) |-> $past(ctlWr && pwdata[4]) || $past(ctlWr && pwdata[4], 2))
    else $error("move began without an enable write");
  stop_enable_a: assert property (ctlWr && !pwdata[4] |-> ##[1:2] !moving)
    else $error("move kept running after enable cleared");
  stop_quick_a: assert property (ctlWr && !pwdata[2] |-> ##[1:2] !moving)
    else $error("move kept running after quick stop");
  stop_halt_a: assert property (ctlWr && pwdata[8] |-> ##[1:2] !moving)
    else $error("move kept running after halt");
  flush_abort_a: assert property (cmdWr && pwdata[7:0] == 8'h80 |-> ##[1:2] !moving)
    else $error("move kept running after flush");
  // ==========================================================
  // Configuration, buffer head and map
  sub_mode_a: assert property
    (anyWr && paddr == ITSB_CONFIG_OFS |=> subMode == $past(pwdata[7:0]))
    else $error("submode output differs from config write");
  head_hold_a: assert property
    (!spanDone && !$past(spanDone) && !anyWr && !$past(anyWr)
      |=> $stable(spanStartPos) && $stable(spanTime))
    else $error("buffer head changed with no pop or push");
  map_error_a: assert property (psel && penable && paddr > ITSB_STATUS_OFS |-> pslverr && pready)
    else $error("unmapped access not refused");
  cover property ($rose(moving));
  cover property ($fell(moving) && $past(spanDone));
  cover property (psel && penable && pslverr);
endmodule
bind itsb_top itsb_checker #(.DEPTH(DEPTH)) u_chk (.*);
`default_nettype wire

/* File: tb/itsb_net_master.sv */
// Network master stand-in: issues register transfers on APB.
// Assumes the bench calls xfer from one process at a time.
`timescale 1ns/1ps
`default_nettype none
module itsb_net_master (
  input wire logic clk,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata
);
  // ==========================================================
  // Idle bus at time zero
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end
  // One transfer; released address and data lines show inverted values so stale data never looks valid
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench for the trajectory segment buffer.
// Assumes the bound checker and the APB master model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import itsb_pkg::*;
  logic clk, sys_rst, ce, psel, penable, pwrite, pready, pslverr, spanDone, syncTick, moving;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, spanStartPos, spanEndPos, spanStartVel, spanEndVel;
  logic signed [7:0] subMode;
  logic [15:0] spanTime;
  logic [72:0] rows [8];
  logic [31:0] stopWord [3];
  int miscompares = 0;
  int testsRun = 0;
  itsb_top DUT (.*);
  itsb_net_master M (.*);
  // ==========================================================
  // Clock, watchdog and verdict
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    test_done;
  end
  task automatic test_done;
    if (miscompares == 0 && testsRun > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ==========================================================
  // Helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    M.xfer(1'b1, a, d, q, e);
  endtask
  task automatic st(input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    M.xfer(1'b0, ITSB_STATUS_OFS, 32'h0000_0000, q, e);
    chk(q, exp);
  endtask
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask
  // Enable low then high, so every start is a fresh rising edge
  task automatic go;
    wr(ITSB_CTRL_OFS, 32'h0000_0004);
    wr(ITSB_CTRL_OFS, 32'h0000_0014);
    settle;
  endtask
  task automatic push(input logic [6:0] id, input logic [15:0] t);
    wr(ITSB_SEG_POS_OFS, 32'h0000_1000 + {25'h0, id});
    wr(ITSB_SEG_VEL_OFS, 32'h0000_2000 + {25'h0, id});
    wr(ITSB_SEG_CMD_OFS, {8'h00, t, 1'b0, id});
  endtask
  task automatic span(input logic s);
    @(posedge clk);
    spanDone <= 1'b1;
    syncTick <= s;
    @(posedge clk);
    spanDone <= 1'b0;
    syncTick <= 1'b0;
    settle;
  endtask
  // ==========================================================
  // Main sequence
  initial
  begin
    logic [31:0] q;
    logic e;
    sys_rst = 1'b1;
    ce = 1'b1;
    spanDone = 1'b0;
    syncTick = 1'b0;
    rows = '{{1'b0, 8'h18, 32'hFFFF_FFFF, 32'h2000_0000}, {1'b0, 8'h00, 32'hFFFF_0104, 32'h0000_0104},
             {1'b0, 8'h04, 32'h0000_0100, 32'h0000_0100}, {1'b0, 8'h04, 32'h0000_00FF, 32'h0000_00FF},
             {1'b0, 8'h08, 32'h0000_1234, 32'h0000_1234}, {1'b1, 8'h1C, 32'h0000_0055, 32'h0000_0000},
             {1'b1, 8'h40, 32'h0000_0055, 32'h0000_0000}, {1'b0, 8'h04, 32'h0000_00FE, 32'h0000_00FE}};
    stopWord = '{32'h0000_0114, 32'h0000_0010, 32'h0000_0004};
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    chk({24'h0, subMode}, 32'h0000_00FE);
    // Register rows: write, refusal flag, read back, submode output
    for (int i = 0; i < 8; i++)
    begin
      M.xfer(1'b1, rows[i][71:64], rows[i][63:32], q, e);
      chk({31'h0, e}, {31'h0, rows[i][72]});
      M.xfer(1'b0, rows[i][71:64], 32'h0000_0000, q, e);
      chk(q, rows[i][31:0]);
      if (rows[i][71:64] == ITSB_CONFIG_OFS)
        chk({24'h0, subMode}, {24'h0, rows[i][7:0]});
    end
    // Preload the whole buffer, then overflow and sequencing faults
    for (int i = 0; i < 32; i++)
      push(i[6:0], 16'h0010);
    st(32'h0020_2000);
    push(7'h20, 16'h0010);
    st(32'h0020_2002);
    push(7'h05, 16'h0010);
    st(32'h0020_2006);
    push(7'h20, 16'h0010);
    st(32'h0020_2006);
    wr(ITSB_SEG_CMD_OFS, 32'h0000_0081);
    st(32'h0020_2000);
    // Start, span ends and the head moves on
    go;
    chk(spanStartPos, 32'h0000_1000);
    chk(spanEndPos, 32'h0000_1001);
    chk(spanStartVel, 32'h0000_2000);
    chk(spanEndVel, 32'h0000_2001);
    chk({16'h0, spanTime}, 32'h0000_0010);
    span(1'b0);
    chk(spanStartPos, 32'h0000_1001);
    st(32'h011F_2008);
    // Each abort word stops at once
    for (int i = 0; i < 3; i++)
    begin
      go;
      chk({31'h0, moving}, 32'h0000_0001);
      wr(ITSB_CTRL_OFS, stopWord[i]);
      settle;
      chk({31'h0, moving}, 32'h0000_0000);
    end
    go;
    wr(ITSB_SEG_CMD_OFS, 32'h0000_0080);
    settle;
    chk({31'h0, moving}, 32'h0000_0000);
    st(32'h2000_2000);
    go;
    chk({31'h0, moving}, 32'h0000_0000);
    st(32'h2000_2001);
    wr(ITSB_SEG_CMD_OFS, 32'h0000_0081);
    // Zero time in the following entry ends the move after this span
    push(7'h20, 16'h0005);
    push(7'h21, 16'h0000);
    go;
    st(32'h1E02_2218);
    span(1'b0);
    chk({31'h0, moving}, 32'h0000_0000);
    st(32'h2000_2200);
    // Synchronized run: span end alone does not advance; with sync it runs dry
    wr(ITSB_CONFIG_OFS, 32'h0000_01FE);
    push(7'h22, 16'h0007);
    push(7'h23, 16'h0007);
    go;
    span(1'b0);
    chk({31'h0, moving}, 32'h0000_0001);
    span(1'b1);
    st(32'h1F01_2401);
    // Constant-time mode: the interval gives the time, a zero interval ends the move
    wr(ITSB_SEG_CMD_OFS, 32'h0000_0080);
    wr(ITSB_CONFIG_OFS, 32'h0000_0000);
    wr(ITSB_INTERVAL_OFS, 32'h0000_0009);
    push(7'h24, 16'h7777);
    // A write while ce is low is lost
    ce <= 1'b0;
    wr(ITSB_INTERVAL_OFS, 32'h0000_0000);
    ce <= 1'b1;
    M.xfer(1'b0, ITSB_INTERVAL_OFS, 32'h0000_0000, q, e);
    chk(q, 32'h0000_0009);
    wr(ITSB_INTERVAL_OFS, 32'h0000_0000);
    push(7'h25, 16'h7777);
    go;
    chk({16'h0, spanTime}, 32'h0000_0009);
    st(32'h1E02_2618);
    // Reset in mid-move: outputs and status return to their reset values
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    chk({31'h0, moving}, 32'h0000_0000);
    chk({24'h0, subMode}, 32'h0000_00FE);
    st(32'h2000_0000);
    test_done;
  end
endmodule
`default_nettype wire
